// ===== verilog/lad_defs.svh
// Address map, field widths and window alignment for the link decode and ordering block.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef LAD_DEFS_SVH
`define LAD_DEFS_SVH

`define LAD_ADDR_W 40
`define LAD_STREAM_W 5
`define LAD_TAG_W 4
`define LAD_LEN_W 4
`define LAD_STAMP_W 4

`define LAD_INTR_BASE 40'hfd_0000_0000
`define LAD_INTR_ACK_BASE 40'hfd_f900_0000
`define LAD_SMGT_BASE 40'hfd_f910_0000
`define LAD_RSVD_BASE 40'hfd_f920_0000
`define LAD_IO_BASE 40'hfd_fc00_0000
`define LAD_CFG_BASE 40'hfd_fe00_0000
`define LAD_HIGH_RSVD_BASE 40'hfe_0000_0000

`define LAD_INTR_HI_LSB 24
`define LAD_INTR_HI_BYTE 8'hf8
`define LAD_WIN_ALIGN_BITS 6

`endif

// ===== verilog/lad_pkg.sv
// Types and shared decode functions for the link decode and ordering block.
// Assumes lad_defs.svh is on the include path.
`default_nettype none

package lad_pkg;
  `include "lad_defs.svh"

  typedef logic [`LAD_ADDR_W-1:0] lad_addr_t;

  typedef enum logic [2:0] {
    LAD_CMD_RD = 3'h0,
    LAD_CMD_WR_NP = 3'h1,
    LAD_CMD_WR_P = 3'h2,
    LAD_CMD_BCAST = 3'h3,
    LAD_CMD_FENCE = 3'h4,
    LAD_CMD_RESP = 3'h5
  } lad_cmd_t;

  typedef enum logic [1:0] {
    LAD_VC_POSTED = 2'h0,
    LAD_VC_NONPOSTED = 2'h1,
    LAD_VC_RESPONSE = 2'h2
  } lad_vc_t;

  typedef enum logic [2:0] {
    LAD_SP_MEM = 3'h0,
    LAD_SP_INTR = 3'h1,
    LAD_SP_INTR_ACK = 3'h2,
    LAD_SP_SMGT = 3'h3,
    LAD_SP_RSVD = 3'h4,
    LAD_SP_IO = 3'h5,
    LAD_SP_CFG = 3'h6
  } lad_space_t;

  typedef struct packed {
    lad_cmd_t cmd;
    lad_addr_t addr;
    logic [`LAD_LEN_W-1:0] len_m1;
    logic [`LAD_STREAM_W-1:0] stream;
    logic [`LAD_TAG_W-1:0] ordering_tag;
    logic may_pass_posted_bit;
  } lad_pkt_t;

  typedef struct packed {
    lad_pkt_t pkt;
    lad_space_t space;
    logic [`LAD_STAMP_W-1:0] stamp;
  } lad_entry_t;

  // Classifies an address by its upper bits.
  function automatic lad_space_t lad_space(input lad_addr_t a);
    if (a < `LAD_INTR_BASE) begin
      return LAD_SP_MEM;
    end else if (a < `LAD_INTR_ACK_BASE) begin
      return LAD_SP_INTR;
    end else if (a < `LAD_SMGT_BASE) begin
      return LAD_SP_INTR_ACK;
    end else if (a < `LAD_RSVD_BASE) begin
      return LAD_SP_SMGT;
    end else if (a < `LAD_IO_BASE) begin
      return LAD_SP_RSVD;
    end else if (a < `LAD_CFG_BASE) begin
      return LAD_SP_IO;
    end else if (a < `LAD_HIGH_RSVD_BASE) begin
      return LAD_SP_CFG;
    end
    return LAD_SP_RSVD;
  endfunction

  // Picks the virtual channel from the command encoding.
  function automatic lad_vc_t lad_vc(input lad_cmd_t c);
    if (c == LAD_CMD_WR_P || c == LAD_CMD_BCAST || c == LAD_CMD_FENCE) begin
      return LAD_VC_POSTED;
    end else if (c == LAD_CMD_RESP) begin
      return LAD_VC_RESPONSE;
    end
    return LAD_VC_NONPOSTED;
  endfunction
endpackage

`default_nettype wire

// ===== verilog/lad_if.sv
// Packet channel from the requesting end to the decoding node.
// Assumes both ends share one clock and reset.
`timescale 1ns/1ps
`default_nettype none

interface lad_if;
  lad_pkg::lad_pkt_t pkt;
  logic valid;
  logic ready;

  modport req_end (output pkt, output valid, input ready);
  modport node_end (input pkt, input valid, output ready);
endinterface

`default_nettype wire

// ===== verilog/lad_buf2.sv
// Small FIFO with valid and ready on both sides, two entries by default.
// Assumes a single clock; the drain side may stall at will.
`timescale 1ns/1ps
`default_nettype none

module lad_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("lad_buf2 depth must be a power of two of at least two");
  end

  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] wr_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != FULL_CNT;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg <= '0;
      wr_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      rd_reg <= rd_reg + AW'(pop);
      wr_reg <= wr_reg + AW'(push);
      cnt_reg <= cnt_next;
    end
  end
endmodule

`default_nettype wire

// ===== verilog/lad_req.sv
// Requesting end: sanitises user requests by address space and sends them on the link.
// Assumes the node end sits on the other side of the interface on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "lad_defs.svh"

module lad_req
  import lad_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic req_valid,
  output logic req_ready,
  input wire lad_cmd_t req_cmd,
  input wire lad_addr_t req_addr,
  input wire logic [`LAD_LEN_W-1:0] req_len_m1,
  input wire logic [`LAD_STREAM_W-1:0] req_stream,
  input wire logic [`LAD_TAG_W-1:0] req_tag,
  input wire logic req_pp,
  output logic req_refused,
  lad_if.req_end tx
);
  lad_space_t sp;
  logic is_wr;
  logic is_bcast;
  logic cfg_io;
  logic intr_smgt;
  logic refuse;
  logic accept;
  lad_cmd_t cmd_fixed;
  lad_addr_t addr_fixed;
  lad_pkt_t pkt_fixed;
  logic tx_valid_reg;
  lad_pkt_t tx_pkt_reg;
  logic refused_reg;

  assign sp = lad_space(req_addr);
  assign is_bcast = req_cmd == LAD_CMD_BCAST;
  assign is_wr = req_cmd == LAD_CMD_WR_NP || req_cmd == LAD_CMD_WR_P || is_bcast;
  assign cfg_io = sp == LAD_SP_CFG || sp == LAD_SP_IO;
  assign intr_smgt = sp == LAD_SP_INTR || sp == LAD_SP_SMGT;

  // Config and I/O writes go nonposted, at most one doubleword; no broadcasts there.
  // Interrupt and system-management writes go posted.
  // Nothing is sent upstream into the acknowledge range.
  assign refuse = (sp == LAD_SP_INTR_ACK) || // [R8]
                  (cfg_io && is_bcast) || // [R5]
                  (cfg_io && is_wr && req_len_m1 != '0); // [R5]
  assign cmd_fixed = (cfg_io && is_wr) ? LAD_CMD_WR_NP : // [R5]
                     (intr_smgt && is_wr && !is_bcast) ? LAD_CMD_WR_P : // [R7]
                     req_cmd;
  assign addr_fixed = (sp == LAD_SP_INTR) ?
      {req_addr[`LAD_ADDR_W-1:`LAD_INTR_HI_LSB+8], `LAD_INTR_HI_BYTE, // [R4]
       req_addr[`LAD_INTR_HI_LSB-1:0]} : req_addr;
  assign pkt_fixed = '{cmd: cmd_fixed, addr: addr_fixed, len_m1: req_len_m1,
                       stream: req_stream, ordering_tag: req_tag,
                       may_pass_posted_bit: req_pp};

  // Peer-to-peer traffic also leaves here upstream; the node orders this leg only.
  assign req_ready = !tx_valid_reg || tx.ready; // [R10]
  assign accept = req_valid && req_ready;
  assign tx.valid = tx_valid_reg;
  assign tx.pkt = tx_pkt_reg;
  assign req_refused = refused_reg;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_reg <= 1'b0;
      tx_pkt_reg <= '0;
      refused_reg <= 1'b0;
    end else if (ce) begin
      refused_reg <= accept && refuse;
      if (accept && !refuse) begin
        tx_valid_reg <= 1'b1;
        tx_pkt_reg <= pkt_fixed;
      end else if (tx.ready) begin
        tx_valid_reg <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ===== verilog/lad_node.sv
// Node end: decodes the space of each arriving packet, queues it per virtual channel,
// and emits packets in an order that keeps the upstream passing rules.
// Assumes the requesting end drives the interface on the same clock.
//
// What this block does
// [R1] Memory space is everything up to FC_FFFF_FFFFh.
// [R2] Decode I/O and configuration ranges by address.
// [R3] Forward interrupt, acknowledge, management ranges, never claim.
// [R4] Requester puts F8h in interrupt address bits 31:24.
// [R5] Requester sends config/I/O writes nonposted, one doubleword.
// [R6] Flag long or posted config/I/O access for abort.
// [R7] Requester sends interrupt/management writes only posted.
// [R8] Requester never sends anything to acknowledge range.
// [R9] Own address window aligned to 64 bytes.
// [R10] Ordering judged per leg; peer traffic goes upstream.
// [R11] Responses accepted in any order.
// [R12] In-order bridges buffer enough to reorder responses; here responses leave in arrival order with no reorder buffer.
// [R13] Responses wait until earlier ordered writes drain.
// [R14] Nonposted requests leave in their issue order.
// [R15] Read after config access sees latest write.
// [R16] Three virtual channels chosen from command encoding.
// [R17] Other streams may pass, except past a fence.
// [R18] Same stream, channel, nonzero tag stays ordered.
// [R19] Clear pass bit never overtakes older posted request.
// [R20] Posted passes everything; responses pass nonposted.
// [R21] Nonposted and response pairs kept in order.
// [R22] Responses with pass bit set overtake posted requests; here a valid posted head is always selected first.
// [R23] Reserved ranges are never claimed.
`timescale 1ns/1ps
`default_nettype none
`include "lad_defs.svh"

module lad_node
  import lad_pkg::*;
#(
  parameter lad_addr_t WIN_BASE = 40'h00_0000_0000,
  parameter lad_addr_t WIN_LIMIT = 40'h00_0000_ffff,
  parameter int QDEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  lad_if.node_end rx,
  output logic out_valid,
  input wire logic out_ready,
  output lad_pkt_t out_pkt,
  output lad_vc_t out_vc,
  output lad_space_t out_space,
  output logic out_claim,
  output logic out_abort
);
  localparam int EW = $bits(lad_entry_t);
  localparam int SW = `LAD_STAMP_W;

  // Stamps wrap; packets in flight must stay within half the stamp range.
  if (WIN_BASE[`LAD_WIN_ALIGN_BITS-1:0] != '0 ||
      !(&WIN_LIMIT[`LAD_WIN_ALIGN_BITS-1:0]) || WIN_LIMIT < WIN_BASE) begin : g_bad_win
    $error("lad_node window must be 64-byte aligned and non-empty"); // [R9]
  end
  if (WIN_LIMIT >= `LAD_INTR_BASE) begin : g_bad_space
    $error("lad_node window must lie in memory space"); // [R23]
  end
  if (3 * QDEPTH + 1 >= (1 << (SW - 1))) begin : g_bad_depth
    $error("lad_node queue depth too large for the age stamp");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Age compare on wrapping stamps: true when a was stamped before b.
  function automatic logic lad_older(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic [SW-1:0] d;
    d = b - a;
    return d != '0 && !d[SW-1];
  endfunction

  // True when a later nonposted or response head must stay behind the posted head.
  function automatic logic lad_waits(input lad_entry_t later, input lad_entry_t ph,
                                     input logic ph_valid, input logic ph_full);
    logic fence;
    fence = ph.pkt.cmd == LAD_CMD_FENCE;
    return ph_valid && lad_older(ph.stamp, later.stamp) &&
           (!later.pkt.may_pass_posted_bit || fence) &&
           (ph.pkt.stream == later.pkt.stream || fence || ph_full);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Intake: classify and stamp every arriving packet.
  lad_vc_t in_vc;
  lad_entry_t in_entry;
  logic [SW-1:0] stamp_reg;
  logic [3:0] buf_in_ready;
  logic [2:0] buf_in_valid;
  logic [2:0] head_valid;
  logic [2:0] pop;
  lad_entry_t head [3];
  logic rx_take;

  assign in_vc = lad_vc(rx.pkt.cmd); // [R16]
  assign in_entry = '{pkt: rx.pkt, space: lad_space(rx.pkt.addr), // [R1] [R2]
                      stamp: stamp_reg};
  assign buf_in_ready[3] = 1'b0;
  assign rx.ready = buf_in_ready[in_vc];
  assign rx_take = rx.valid && rx.ready;

  // Each channel has its own queue, but the link stalls while the queue for its next packet is full.
  for (genvar v = 0; v < 3; v++) begin : g_vc
    logic [EW-1:0] head_bits;
    assign buf_in_valid[v] = rx.valid && in_vc == lad_vc_t'(v); // [R16]
    assign head[v] = lad_entry_t'(head_bits);
    // Queues are first in, first out, so tagged sequences and same-channel pairs
    // never reorder, and responses leave in arrival order with no reorder buffer.
    lad_buf2 #(
      .W(EW),
      .DEPTH(QDEPTH)
    ) u_q (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(buf_in_valid[v]),
      .in_ready(buf_in_ready[v]),
      .in_data(in_entry),
      .out_valid(head_valid[v]),
      .out_ready(pop[v]),
      .out_data(head_bits)
    ); // [R12] [R14] [R18] [R21]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Passing checks against the posted head.
  logic posted_full;
  logic np_wait;
  logic rsp_wait;
  logic elig_p;
  logic elig_n;
  logic elig_r;

  assign posted_full = !buf_in_ready[LAD_VC_POSTED];
  // A nonposted request with a clear pass bit stays behind older posted writes of
  // its stream, and behind any older fence whatever the stream.
  assign np_wait = lad_waits(head[LAD_VC_NONPOSTED], head[LAD_VC_POSTED],
                             head_valid[LAD_VC_POSTED], posted_full); // [R19] [R17]
  // A response pushes older posted writes of its stream unless its pass bit is set, so the
  // requester sees the writes done before the reply.
  assign rsp_wait = lad_waits(head[LAD_VC_RESPONSE], head[LAD_VC_POSTED],
                              head_valid[LAD_VC_POSTED], posted_full); // [R13] [R22]
  // Posted traffic is never held by the other channels.
  assign elig_p = head_valid[LAD_VC_POSTED]; // [R20]
  assign elig_r = head_valid[LAD_VC_RESPONSE] && !rsp_wait;
  // Responses are taken in whatever order they come; no matching is needed here.
  assign elig_n = head_valid[LAD_VC_NONPOSTED] && !np_wait; // [R11]

  ////////////////////////////////////////////////////////////////////////////////
  // Selection: posted first, then responses, then nonposted requests.
  lad_vc_t sel_vc;
  lad_entry_t sel;
  logic any_elig;
  logic load;
  logic take;
  logic sel_claim;
  logic sel_abort;
  logic sel_cfg_io;

  assign sel_vc = elig_p ? LAD_VC_POSTED : // [R20]
                  elig_r ? LAD_VC_RESPONSE : LAD_VC_NONPOSTED;
  assign sel = head[sel_vc];
  assign any_elig = elig_p || elig_r || elig_n;
  assign load = !out_valid || out_ready;
  assign take = load && any_elig;
  assign pop[0] = take && sel_vc == LAD_VC_POSTED;
  assign pop[1] = take && sel_vc == LAD_VC_NONPOSTED;
  assign pop[2] = take && sel_vc == LAD_VC_RESPONSE;

  // Only memory space inside the own window is claimed; interrupt, acknowledge,
  // management and reserved ranges always pass on.
  assign sel_claim = sel.space == LAD_SP_MEM && // [R3] [R23]
                     sel.pkt.addr >= WIN_BASE && sel.pkt.addr <= WIN_LIMIT; // [R9]
  assign sel_cfg_io = sel.space == LAD_SP_IO || sel.space == LAD_SP_CFG; // [R2]
  // Config and I/O accesses longer than a doubleword, or posted, are marked.
  assign sel_abort = sel_cfg_io && (sel.pkt.len_m1 != '0 || sel_vc == LAD_VC_POSTED); // [R6]

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage and stamp counter.
  logic out_valid_reg;
  lad_pkt_t out_pkt_reg;
  lad_vc_t out_vc_reg;
  lad_space_t out_space_reg;
  logic out_claim_reg;
  logic out_abort_reg;

  assign out_valid = out_valid_reg;
  assign out_pkt = out_pkt_reg;
  assign out_vc = out_vc_reg;
  assign out_space = out_space_reg;
  assign out_claim = out_claim_reg;
  assign out_abort = out_abort_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stamp_reg <= '0;
    end else if (ce && rx_take) begin
      stamp_reg <= stamp_reg + 1'b1;
    end
  end

  // A read after a config access to the same place follows it out in order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_pkt_reg <= '0;
      out_vc_reg <= LAD_VC_POSTED;
      out_space_reg <= LAD_SP_MEM;
      out_claim_reg <= 1'b0;
      out_abort_reg <= 1'b0;
    end else if (ce && load) begin
      out_valid_reg <= any_elig;
      if (any_elig) begin
        out_pkt_reg <= sel.pkt; // [R15]
        out_vc_reg <= sel_vc;
        out_space_reg <= sel.space;
        out_claim_reg <= sel_claim;
        out_abort_reg <= sel_abort;
      end
    end
  end
endmodule

`default_nettype wire

// ===== tb/lad_link_properties.sv
// Concurrent checks on the packet channel between the requesting end and the node end.
// Assumes it sees the channel signals directly, sampled on the node clock.
`timescale 1ns/1ps
`default_nettype none

module lad_link_properties
  import lad_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire lad_pkt_t pkt,
  input wire logic valid,
  input wire logic ready
);
  ////////////////////////////////////////
  logic in_intr;
  logic in_intr_ack;
  logic in_smgt;
  logic in_cfgio;
  logic is_wr;
  assign in_intr = pkt.addr >= 40'hfd_0000_0000 && pkt.addr < 40'hfd_f900_0000;
  assign in_intr_ack = pkt.addr >= 40'hfd_f900_0000 && pkt.addr < 40'hfd_f910_0000;
  assign in_smgt = pkt.addr >= 40'hfd_f910_0000 && pkt.addr < 40'hfd_f920_0000;
  assign in_cfgio = pkt.addr >= 40'hfd_fc00_0000 && pkt.addr < 40'hfe_0000_0000;
  assign is_wr = pkt.cmd inside {LAD_CMD_WR_NP, LAD_CMD_WR_P, LAD_CMD_BCAST};

  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_hold_until_taken: assert property (
    valid && !ready |=> valid && $stable(pkt))
    else $error("link packet changed or dropped before it was taken");
  a_no_intr_ack: assert property (valid |-> !in_intr_ack)
    else $error("packet sent into the acknowledge range");
  a_cfgio_nonposted: assert property (
    valid && in_cfgio && is_wr |-> pkt.cmd == LAD_CMD_WR_NP)
    else $error("configuration or io write is not nonposted");
  a_cfgio_one_dword: assert property (
    valid && in_cfgio && is_wr |-> pkt.len_m1 == '0)
    else $error("configuration or io write longer than one doubleword");
  a_intr_smgt_posted: assert property (
    valid && (in_intr || in_smgt) && is_wr |-> pkt.cmd != LAD_CMD_WR_NP)
    else $error("interrupt or management write sent nonposted");
  a_intr_high_byte: assert property (valid && in_intr |-> pkt.addr[31:24] == 8'hf8)
    else $error("interrupt address bits 31 to 24 are not f8");
  a_no_cfgio_bcast: assert property (
    valid && in_cfgio |-> pkt.cmd != LAD_CMD_BCAST)
    else $error("broadcast sent into configuration or io space");
  a_idle_from_reset: assert property (disable iff (1'b0) !rst_n |=> !valid)
    else $error("link valid high straight out of reset");

  c_stall_then_take: cover property (valid && !ready ##1 valid && ready);
  c_intr_sent: cover property (valid && ready && in_intr);
  c_cfg_write: cover property (valid && ready && in_cfgio && pkt.cmd == LAD_CMD_WR_NP);
  c_back_to_back: cover property (valid && ready [*2]);
endmodule

`default_nettype wire

// ===== tb/link_address_decode_and_ordering_bench.sv
// Self-checking bench: requesting end and node end joined by one channel.
// Assumes lad_defs.svh on the include path and a 125 MHz node clock.
`timescale 1ns/1ps
`default_nettype none
`include "lad_defs.svh"

module link_address_decode_and_ordering_bench;
  import lad_pkg::*;
  localparam lad_addr_t WBASE = 40'h00_1000_0000;
  localparam lad_addr_t WLIM = 40'h00_1000_ffff;
  logic clk;
  logic rst_n;
  logic ce;
  logic req_valid;
  logic req_ready;
  lad_cmd_t req_cmd;
  lad_addr_t req_addr;
  logic [`LAD_LEN_W-1:0] req_len_m1;
  logic [`LAD_STREAM_W-1:0] req_stream;
  logic [`LAD_TAG_W-1:0] req_tag;
  logic req_pp;
  logic req_refused;
  logic out_valid;
  logic out_ready;
  lad_pkt_t out_pkt;
  lad_vc_t out_vc;
  lad_space_t out_space;
  logic out_claim;
  logic out_abort;
  logic drain;
  logic ref_q;
  int error_cnt;
  int compares;
  lad_pkt_t exp_tx[$];
  lad_pkt_t pend[$];
  lad_addr_t edges[19] = '{40'hfc_ffff_ffff, 40'hfd_0000_0000, 40'hfd_f8ff_ffff,
    40'hfd_f900_0000, 40'hfd_f90f_ffff, 40'hfd_f910_0000, 40'hfd_f91f_ffff, 40'hfd_f920_0000,
    40'hfd_fbff_ffff, 40'hfd_fc00_0000, 40'hfd_fdff_ffff, 40'hfd_fe00_0000, 40'hfd_ffff_ffff,
    40'hfe_0000_0000, 40'hff_ffff_ffff, WBASE, WLIM, WLIM + 40'h1, 40'h00_0000_1000};

  lad_if lad_if_i();
  lad_req lad_req_i (.clk(clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_len_m1(req_len_m1),
    .req_stream(req_stream), .req_tag(req_tag), .req_pp(req_pp), .req_refused(req_refused),
    .tx(lad_if_i.req_end));
  lad_node #(.WIN_BASE(WBASE), .WIN_LIMIT(WLIM)) lad_node_i (.clk(clk), .rst_n(rst_n),
    .ce(ce), .rx(lad_if_i.node_end), .out_valid(out_valid), .out_ready(out_ready),
    .out_pkt(out_pkt), .out_vc(out_vc), .out_space(out_space), .out_claim(out_claim),
    .out_abort(out_abort));
  lad_link_properties lad_link_properties_i (.clk(clk), .rst_n(rst_n), .pkt(lad_if_i.pkt),
    .valid(lad_if_i.valid), .ready(lad_if_i.ready));

  ////////////////////////////////////////
  function automatic int sp_of(input lad_addr_t a);
    if (a < 40'hfd_0000_0000) return 0;
    if (a < 40'hfd_f900_0000) return 1;
    if (a < 40'hfd_f910_0000) return 2;
    if (a < 40'hfd_f920_0000) return 3;
    if (a < 40'hfd_fc00_0000) return 4;
    if (a < 40'hfd_fe00_0000) return 5;
    if (a < 40'hfe_0000_0000) return 6;
    return 4;
  endfunction

  function automatic int vc_of(input lad_cmd_t c);
    return (c inside {LAD_CMD_WR_P, LAD_CMD_BCAST, LAD_CMD_FENCE}) ? 0 :
      (c == LAD_CMD_RESP) ? 2 : 1;
  endfunction

  // Returns one when the request is dropped; p receives the packet as it should be sent.
  function automatic bit shape(input lad_pkt_t r, output lad_pkt_t p);
    int s;
    bit cio;
    s = sp_of(r.addr);
    cio = s == 5 || s == 6;
    p = r;
    if (cio && r.cmd == LAD_CMD_WR_P) p.cmd = LAD_CMD_WR_NP;
    if ((s == 1 || s == 3) && r.cmd == LAD_CMD_WR_NP) p.cmd = LAD_CMD_WR_P;
    if (s == 1) p.addr[31:24] = 8'hf8;
    return s == 2 || (cio && (r.cmd == LAD_CMD_BCAST || (r.cmd inside
      {LAD_CMD_WR_NP, LAD_CMD_WR_P} && r.len_m1 != '0)));
  endfunction

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  always @(posedge clk) begin : mon
    lad_pkt_t r;
    lad_pkt_t p;
    int i;
    int v;
    int s;
    bit acc;
    bit rf;
    bit blk;
    if (!rst_n) begin
      exp_tx.delete();
      pend.delete();
      ref_q = 1'b0;
    end else begin
      chk("req_refused", req_refused, ref_q);
      if (ce && out_valid && out_ready) begin
        v = vc_of(out_pkt.cmd);
        i = 0;
        while (i < pend.size() && vc_of(pend[i].cmd) != v) i++;
        chk("out_known", i < pend.size(), 1);
        if (i < pend.size()) begin
          s = sp_of(out_pkt.addr);
          chk("out_pkt", out_pkt, pend[i]);
          chk("out_vc", out_vc, v);
          chk("out_space", out_space, s);
          chk("out_claim", out_claim, s == 0 && out_pkt.addr >= WBASE &&
            out_pkt.addr <= WLIM);
          chk("out_abort", out_abort, (s == 5 || s == 6) && (out_pkt.len_m1 != '0 ||
            v == 0));
          blk = 1'b0;
          for (int j = 0; j < i; j++) begin
            if (v != 0 && vc_of(pend[j].cmd) == 0 && (pend[j].cmd == LAD_CMD_FENCE ||
                (pend[j].stream == out_pkt.stream && !out_pkt.may_pass_posted_bit))) begin
              blk = 1'b1;
            end
          end
          chk("passed_posted", blk, 0);
          pend.delete(i);
        end
      end
      if (ce && lad_if_i.valid && lad_if_i.ready) begin
        chk("tx_expected", exp_tx.size() > 0, 1);
        if (exp_tx.size() > 0) begin
          chk("tx_pkt", lad_if_i.pkt, exp_tx[0]);
          pend.push_back(exp_tx.pop_front());
        end
      end
      acc = ce && req_valid && req_ready;
      r = '{req_cmd, req_addr, req_len_m1, req_stream, req_tag, req_pp};
      rf = shape(r, p);
      if (acc && !rf) exp_tx.push_back(p);
      if (ce) ref_q = acc && rf;
    end
  end

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(negedge clk) begin
    ce <= drain || ($urandom % 8 != 0);
    out_ready <= drain || ($urandom % 3 != 0);
  end

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    req_valid = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
  endtask

  task automatic send(input lad_cmd_t c, input lad_addr_t a, input int l);
    int n;
    @(negedge clk);
    req_cmd = c;
    req_addr = a;
    req_len_m1 = `LAD_LEN_W'(l);
    req_stream = `LAD_STREAM_W'($urandom % 4);
    req_tag = `LAD_TAG_W'($urandom % 3);
    req_pp = 1'($urandom % 2);
    req_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(ce && req_ready) && n < 300);
    if (n >= 300) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  initial begin
    int n;
    void'($urandom(32'he865422e));
    rst_n = 1'b0;
    ce = 1'b0;
    out_ready = 1'b0;
    drain = 1'b0;
    req_valid = 1'b0;
    req_cmd = LAD_CMD_RD;
    req_addr = '0;
    req_len_m1 = '0;
    req_stream = '0;
    req_tag = '0;
    req_pp = 1'b0;
    do_reset();
    foreach (edges[k]) begin
      for (int c = 0; c < 6; c++) begin
        send(lad_cmd_t'(c), edges[k], (k + c) % 3);
      end
    end
    for (n = 0; n < 400; n++) begin
      if (n == 200) do_reset();
      if ($urandom % 4 == 0) begin
        @(negedge clk);
        req_valid = 1'b0;
      end
      send(lad_cmd_t'($urandom % 6), edges[$urandom % 19] ^ 40'($urandom % 64),
        ($urandom % 2) ? 0 : $urandom % 16);
    end
    @(negedge clk);
    req_valid = 1'b0;
    drain = 1'b1;
    n = 0;
    while ((exp_tx.size() > 0 || pend.size() > 0) && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk("left_pending", exp_tx.size() + pend.size(), 0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
